/* File: design/keyed_watchdog_timer.sv */
// Purpose: keyed watchdog timer counting low-speed rc periods
// Assumes: cpu strobes are single-cycle and synchronous to i_clk_sys
// Notes: resets leave as one-cycle pulses for the reset controller
// Functional notes
// - count rc source through 2^8..2^18 divider
// - period select maps eight codes to timeouts
// - always mode: either legal key runs
// - program mode: 10101 off, 01010 on
// - illegal key resets device on the third tick, after 2-3 periods
// - key reset sets fault flag, software clears
// - control register powers up as 0x53
// - normal overflow resets device, sets timeout
// - sleep overflow clears only pc and sp
// - reset, clear or stop clears counter
// - stop with watchdog off halts it
`timescale 1ns/1ps
`include "keyed_wdt_map.svh"
module keyed_watchdog_timer #(
   parameter int CNT_W = `WDT_CNT_W
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_low_speed_rc_osc,
   input wire logic i_cfg_always_en,
   input wire logic i_clear_watchdog_instruction,
   input wire logic i_halt,
   input wire logic i_low_power,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_dev_rst,
   output logic o_pc_sp_clr,
   output logic o_timeout_flag,
   output logic o_power_down_flag,
   output logic o_idle_sysclk_keep_on,
   output logic o_irq
);
   keyed_wdt_pkg::wdt_ctrl_type ctrl_ff;
   keyed_wdt_pkg::reg_req_type req;
   keyed_wdt_pkg::wdt_state_type state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [1:0] fault_cnt_ff;
   logic [7:0] sys_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_mask_ff;
   logic tick;
   logic key_legal;
   logic wdt_on;
   logic ovf_now;
   logic key_rst_now;
   logic clr_evt;
   logic [CNT_W-1:0] term;
   logic [2:0] irq_set;

   function automatic logic [4:0] period_shift(input logic [2:0] sel);
      logic [4:0] s;
      s = 5'h08;
      case (sel)
         3'h0: s = 5'h08;
         3'h1: s = 5'h0A;
         3'h2: s = 5'h0C;
         3'h3: s = 5'h0E;
         3'h4: s = 5'h0F;
         3'h5: s = 5'h10;
         3'h6: s = 5'h11;
         default: s = 5'h12;
      endcase
      return s;
   endfunction

   function automatic logic is_legal(input logic [4:0] key);
      return (key == `WDT_KEY_ON) || (key == `WDT_KEY_OFF);
   endfunction

   assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // rc oscillator is asynchronous, synchronised first
   low_speed_rc_osc_tick_gen u_tick (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_low_speed_rc_osc(i_low_speed_rc_osc),
      .o_tick(tick)
   );

   // either legal key enables in always mode
   // program mode needs the on key
   always_comb begin
      key_legal = is_legal(ctrl_ff.enable_key);
      if (i_cfg_always_en) begin
         wdt_on = key_legal;
      end else begin
         wdt_on = (ctrl_ff.enable_key == `WDT_KEY_ON);
      end
   end

   // terminal count is 2^n - 1 source periods
   assign term = CNT_W'((CNT_W+1)'(1) << period_shift(ctrl_ff.period_select)) - CNT_W'(1);
   assign ovf_now = tick && (state_ff == keyed_wdt_pkg::WDT_COUNT) && (cnt_ff == term);
   // third tick after the bad key gives 2-3 periods
   assign key_rst_now = tick && !key_legal && (fault_cnt_ff == `WDT_KEY_FAULT_TICKS - 2'h1);
   // clear instruction and stop both clear
   assign clr_evt = i_clear_watchdog_instruction || i_halt;

   // stop with watchdog off freezes it until wake
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_ff <= keyed_wdt_pkg::WDT_IDLE;
      end else begin
         case (state_ff)
            keyed_wdt_pkg::WDT_IDLE: begin
               if (i_halt && !wdt_on) begin
                  state_ff <= keyed_wdt_pkg::WDT_HALTED;
               end else if (wdt_on) begin
                  state_ff <= keyed_wdt_pkg::WDT_COUNT;
               end
            end
            keyed_wdt_pkg::WDT_COUNT: begin
               if (!wdt_on) begin
                  state_ff <= i_halt ? keyed_wdt_pkg::WDT_HALTED : keyed_wdt_pkg::WDT_IDLE;
               end
            end
            keyed_wdt_pkg::WDT_HALTED: begin
               if (!i_low_power && !i_halt) begin
                  state_ff <= keyed_wdt_pkg::WDT_IDLE;
               end
            end
            default: state_ff <= keyed_wdt_pkg::WDT_IDLE;
         endcase
      end
   end

   // counter cleared by reset, clear or stop
   // restarts from zero toward current timeout
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cnt_ff <= '0;
      end else if (clr_evt || ovf_now || state_ff != keyed_wdt_pkg::WDT_COUNT) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   // count rc ticks while the key stays illegal
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || key_legal || key_rst_now) begin
         fault_cnt_ff <= 2'h0;
      end else if (tick) begin
         fault_cnt_ff <= fault_cnt_ff + 2'h1;
      end
   end

   // power-up value; a key reset restores it too
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || key_rst_now) begin
         ctrl_ff <= `WDT_CTRL_POR;
      end else if (req.wr && req.addr == `WDT_OFS_CTRL) begin
         ctrl_ff <= req.wdata;
      end
   end

   // fault flag: hardware sets, software writes 0
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sys_ff <= 8'h00;
      end else begin
         if (req.wr && req.addr == `WDT_OFS_SYS) begin
            sys_ff <= (req.wdata & `WDT_SYS_WMASK)
                      | (sys_ff & i_wdata & 8'h01);
         end
         if (key_rst_now) begin
            sys_ff[`WDT_SYS_KEY_FAULT_BIT] <= 1'b1;
         end
      end
   end

   // normal overflow resets the whole device
   // overflow in sleep or idle clears pc and sp only
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_dev_rst <= 1'b0;
         o_pc_sp_clr <= 1'b0;
      end else begin
         o_dev_rst <= (ovf_now && !i_low_power) || key_rst_now;
         o_pc_sp_clr <= ovf_now && i_low_power;
      end
   end

   // timeout flag set on overflow; set wins over clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_timeout_flag <= 1'b0;
         o_power_down_flag <= 1'b0;
      end else begin
         if (ovf_now) begin
            o_timeout_flag <= 1'b1;
         end else if (clr_evt) begin
            o_timeout_flag <= 1'b0;
         end
         if (i_halt) begin
            o_power_down_flag <= 1'b1;
         end else if (i_clear_watchdog_instruction) begin
            o_power_down_flag <= 1'b0;
         end
      end
   end

   // events are sticky; a write of one clears unless the event repeats
   always_comb begin
      irq_set = 3'h0;
      irq_set[`WDT_IRQ_OVF_BIT] = ovf_now && !i_low_power;
      irq_set[`WDT_IRQ_KEY_BIT] = key_rst_now;
      irq_set[`WDT_IRQ_SLEEP_BIT] = ovf_now && i_low_power;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         irq_stat_ff <= 3'h0;
         irq_mask_ff <= 3'h0;
      end else begin
         if (req.wr && req.addr == `WDT_OFS_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~req.wdata[2:0]) | irq_set;
         end else begin
            irq_stat_ff <= irq_stat_ff | irq_set;
         end
         if (req.wr && req.addr == `WDT_OFS_IRQ_MASK) begin
            irq_mask_ff <= req.wdata[2:0];
         end
      end
   end

   // registered, so the line trails the status bit by one cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !req.rd) begin
         o_rdata <= 8'h00;
      end else if (req.addr == `WDT_OFS_CTRL) begin
         o_rdata <= ctrl_ff;
      end else if (req.addr == `WDT_OFS_SYS) begin
         o_rdata <= sys_ff;
      end else if (req.addr == `WDT_OFS_IRQ_STAT) begin
         o_rdata <= {5'h00, irq_stat_ff};
      end else begin
         o_rdata <= {5'h00, irq_mask_ff};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_idle_sysclk_keep_on <= 1'b0;
      end else begin
         o_idle_sysclk_keep_on <= sys_ff[`WDT_SYS_KEEP_ON_BIT];
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   period_match_a: assert property (ovf_now |-> cnt_ff inside {18'h000FF, 18'h003FF,
      18'h00FFF, 18'h03FFF, 18'h07FFF, 18'h0FFFF, 18'h1FFFF, 18'h3FFFF})
      else $error("overflow away from a legal period");
   period_code_a: assert property (
      ctrl_ff.period_select == 3'h2 && ovf_now |-> cnt_ff == 18'h00FFF)
      else $error("code 010 not 2^12 periods");
   always_run_a: assert property (
      i_cfg_always_en && key_legal && state_ff == keyed_wdt_pkg::WDT_IDLE
      && !i_halt |=> state_ff == keyed_wdt_pkg::WDT_COUNT)
      else $error("legal key did not start watchdog");
   prog_off_a: assert property (
      !i_cfg_always_en && ctrl_ff.enable_key == `WDT_KEY_OFF
      |=> state_ff != keyed_wdt_pkg::WDT_COUNT)
      else $error("off key left watchdog running");
   key_delay_a: assert property (
      key_rst_now |-> !key_legal && $past(!key_legal, 2))
      else $error("key reset without illegal key");
   fault_flag_a: assert property (key_rst_now |=> sys_ff[0] && o_dev_rst)
      else $error("key fault flag or reset missing");
   por_value_a: assert property ($past(i_rst) |-> ctrl_ff == `WDT_CTRL_POR)
      else $error("control not at power-up value");
   normal_ovf_a: assert property (
      ovf_now && !i_low_power |=> o_dev_rst && o_timeout_flag && !o_pc_sp_clr)
      else $error("normal overflow did not reset");
   sleep_ovf_a: assert property (
      ovf_now && i_low_power |=> o_pc_sp_clr && !o_dev_rst && o_timeout_flag)
      else $error("sleep overflow wrong reset");
   clear_cnt_a: assert property (clr_evt |=> cnt_ff == '0)
      else $error("clear did not zero counter");
   stop_halt_a: assert property (
      i_halt && !wdt_on |=> state_ff == keyed_wdt_pkg::WDT_HALTED ##1 cnt_ff == '0)
      else $error("stop with watchdog off did not halt");
   restart_a: assert property (
      i_clear_watchdog_instruction && wdt_on && state_ff == keyed_wdt_pkg::WDT_COUNT
      ##1 tick && !clr_evt |=> cnt_ff == CNT_W'(1))
      else $error("count did not restart from zero");

   normal_ovf_c: cover property (ovf_now && !i_low_power);
   sleep_ovf_c: cover property (ovf_now && i_low_power);
   key_fault_c: cover property (key_rst_now);
   stop_c: cover property (state_ff == keyed_wdt_pkg::WDT_HALTED);
endmodule // keyed_watchdog_timer

/* File: design/keyed_wdt_map.svh */
// Purpose: register offsets, fields, reset values and counts of the keyed watchdog
// Assumes: 8-bit register port, one word per offset
// Notes: definitions only
`ifndef KEYED_WDT_MAP_SVH
`define KEYED_WDT_MAP_SVH

`define WDT_ADDR_W 2
`define WDT_OFS_CTRL 2'h0
`define WDT_OFS_SYS 2'h1
`define WDT_OFS_IRQ_STAT 2'h2
`define WDT_OFS_IRQ_MASK 2'h3

`define WDT_CTRL_POR 8'h53
`define WDT_KEY_ON 5'h0A
`define WDT_KEY_OFF 5'h15

`define WDT_SYS_KEEP_ON_BIT 7
`define WDT_SYS_LVR_BIT 2
`define WDT_SYS_LVS_BIT 1
`define WDT_SYS_KEY_FAULT_BIT 0
`define WDT_SYS_WMASK 8'h86

`define WDT_IRQ_OVF_BIT 0
`define WDT_IRQ_KEY_BIT 1
`define WDT_IRQ_SLEEP_BIT 2

`define WDT_CNT_W 18
`define WDT_KEY_FAULT_TICKS 2'h3

`endif

/* File: design/keyed_wdt_pkg.sv */
// Purpose: types shared by the keyed watchdog
// Assumes: nothing
// Notes: constants live in keyed_wdt_map.svh
package keyed_wdt_pkg;

   typedef struct packed {
      logic [4:0] enable_key;
      logic [2:0] period_select;
   } wdt_ctrl_type;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef enum logic [1:0] {
      WDT_IDLE,
      WDT_COUNT,
      WDT_HALTED
   } wdt_state_type;

endpackage

/* File: design/low_speed_rc_osc_tick_gen.sv */
// Purpose: turn the low-speed rc oscillator pin into a one-cycle tick
// Assumes: oscillator far slower than i_clk_sys
// Notes: tick marks each rising edge after a two-stage synchroniser
`timescale 1ns/1ps
module low_speed_rc_osc_tick_gen (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_low_speed_rc_osc,
   output logic o_tick
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
         o_tick <= 1'b0;
      end else begin
         meta_ff <= i_low_speed_rc_osc;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         o_tick <= sync_ff & ~prev_ff;
      end
   end
endmodule // low_speed_rc_osc_tick_gen

/* File: dv/tb_keyed_watchdog_timer.sv */
// Purpose: self-checking bench for keyed_watchdog_timer
// Assumes: rc pin toggles every 4 system clocks, so one source period is 8 clocks
// Notes: only periods 000..010 are timed; the longer ones would make the run too long
`timescale 1ns/1ps
`include "keyed_wdt_map.svh"
module tb_keyed_watchdog_timer;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_low_speed_rc_osc = 1'b0;
   logic i_cfg_always_en = 1'b0;
   logic i_clear_watchdog_instruction = 1'b0;
   logic i_halt = 1'b0;
   logic i_low_power = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_dev_rst, o_pc_sp_clr, o_timeout_flag, o_power_down_flag, o_idle_sysclk_keep_on, o_irq;
   logic [2:0] rc_div = 3'h0;
   int num_errors = 0;
   int tests_run = 0;
   int t;
   // rows: address, write data, expected read-back
   logic [17:0] rows [0:5] = '{{2'h0, 8'hA8, 8'hA8}, {2'h0, 8'hAF, 8'hAF}, {2'h1, 8'hFF, 8'h86},
      {2'h1, 8'h00, 8'h00}, {2'h3, 8'h07, 8'h07}, {2'h2, 8'h07, 8'h00}};
   logic [7:0] rst_vals [0:3] = '{`WDT_CTRL_POR, 8'h00, 8'h00, 8'h00};

   keyed_watchdog_timer dut (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_low_speed_rc_osc(i_low_speed_rc_osc),
      .i_cfg_always_en(i_cfg_always_en),
      .i_clear_watchdog_instruction(i_clear_watchdog_instruction),
      .i_halt(i_halt),
      .i_low_power(i_low_power),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .o_dev_rst(o_dev_rst),
      .o_pc_sp_clr(o_pc_sp_clr),
      .o_timeout_flag(o_timeout_flag),
      .o_power_down_flag(o_power_down_flag),
      .o_idle_sysclk_keep_on(o_idle_sysclk_keep_on),
      .o_irq(o_irq)
   );

   initial begin
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   // a fast rc rate, one period per 8 clocks, keeps the timed periods short
   always @(posedge i_clk_sys) begin
      rc_div <= rc_div + 3'h1;
      i_low_speed_rc_osc <= rc_div[2];
   end

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check1(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [1:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      check8(name, e, o_rdata);
   endtask

   // one-cycle stop (h=1) or clear (h=0) instruction
   task automatic pulse(input logic h);
      @(posedge i_clk_sys);
      if (h) i_halt <= 1'b1;
      else i_clear_watchdog_instruction <= 1'b1;
      @(posedge i_clk_sys);
      i_halt <= 1'b0;
      i_clear_watchdog_instruction <= 1'b0;
   endtask

   // waits up to hi cycles for the chosen reset pulse; the other pulse must stay low
   task automatic measure(input int lo, input int hi, input logic sel, input logic exp,
      input string name);
      int k;
      logic other;
      k = 0;
      other = 1'b0;
      while (k < hi && (sel ? o_pc_sp_clr : o_dev_rst) !== 1'b1) begin
         @(posedge i_clk_sys);
         #1;
         k++;
         if ((sel ? o_dev_rst : o_pc_sp_clr) === 1'b1) other = 1'b1;
      end
      check1(name, exp, k < hi);
      if (exp) check1({name, "_early"}, 1'b0, k < lo);
      check1({name, "_other"}, 1'b0, other);
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1 check1("reset_dev_rst", 1'b0, o_dev_rst);
      for (int i = 0; i < 4; i++) rd_chk("reset_reg", i[1:0], rst_vals[i]);
      end_test("reset");
      foreach (rows[i]) begin
         reg_wr(rows[i][17:16], rows[i][15:8]);
         rd_chk("table_reg", rows[i][17:16], rows[i][7:0]);
         if (rows[i][17:16] == 2'h1) check1("keep_on", rows[i][7], o_idle_sysclk_keep_on);
      end
      end_test("registers");
      for (int p = 0; p < 3; p++) begin
         t = 1 << (8 + 2 * p);
         reg_wr(2'h0, {`WDT_KEY_ON, p[2:0]});
         if (p == 0) measure(0, 1600, 1'b0, 1'b0, "pre_clear");
         pulse(1'b0);
         #1 check1("timeout_clr", 1'b0, o_timeout_flag);
         measure(8 * t - 8, 8 * t + 3, 1'b0, 1'b1, "overflow");
         check1("timeout_set", 1'b1, o_timeout_flag);
         rd_chk("stat_ovf", 2'h2, 8'h01);
         check1("irq_on", 1'b1, o_irq);
         reg_wr(2'h2, 8'h01);
         rd_chk("stat_clr", 2'h2, 8'h00);
         check1("irq_off", 1'b0, o_irq);
      end
      end_test("periods");
      reg_wr(2'h0, 8'h50);
      i_low_power <= 1'b1;
      pulse(1'b1);
      #1 check1("pd_set", 1'b1, o_power_down_flag);
      measure(2040, 2051, 1'b1, 1'b1, "sleep");
      check1("sleep_timeout", 1'b1, o_timeout_flag);
      rd_chk("stat_sleep", 2'h2, 8'h04);
      reg_wr(2'h2, 8'h04);
      i_low_power <= 1'b0;
      pulse(1'b0);
      #1 check1("pd_clr", 1'b0, o_power_down_flag);
      end_test("sleep");
      // off key idles it first, so the always mode must restart it
      reg_wr(2'h0, 8'hA8);
      pulse(1'b0);
      i_cfg_always_en <= 1'b1;
      measure(2040, 2051, 1'b0, 1'b1, "always_on");
      reg_wr(2'h2, 8'h01);
      i_cfg_always_en <= 1'b0;
      pulse(1'b0);
      measure(0, 3000, 1'b0, 1'b0, "prog_off");
      pulse(1'b1);
      #1 check1("halt_off_pd", 1'b1, o_power_down_flag);
      pulse(1'b0);
      end_test("modes");
      reg_wr(2'h0, 8'h00);
      measure(17, 27, 1'b0, 1'b1, "key_fault");
      rd_chk("ctrl_restore", 2'h0, `WDT_CTRL_POR);
      rd_chk("fault_flag", 2'h1, 8'h01);
      rd_chk("stat_key", 2'h2, 8'h02);
      reg_wr(2'h1, 8'h00);
      rd_chk("fault_clr", 2'h1, 8'h00);
      end_test("key_fault");
      reg_wr(2'h0, 8'h51);
      check1("irq_key", 1'b1, o_irq);
      i_rst <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1 check1("rerst_irq", 1'b0, o_irq);
      rd_chk("rerst_ctrl", 2'h0, `WDT_CTRL_POR);
      end_test("mid_reset");
      close_out();
   end

   // the tests take about 52000 cycles
   initial begin
      repeat (90000) @(posedge i_clk_sys);
      num_errors++;
      close_out();
   end
endmodule // tb_keyed_watchdog_timer
